/* inc/mac_txq_pkg.sv */
/*
  Constants, register map and carrier structs for the transmit descriptor
  and status queue engine. Assumes a single 200 MHz system clock domain.
*/
// Operation
// - Descriptor queue is circular, host-set base and length
// - Fetch from current pointer, wrap to base
// - Enqueue writes add; fetch decrements; read returns total
// - Frames span descriptors until end-of-frame flag
// - Medium, preamble, fragments in order, optional CRC
// - First word is 32-bit word-aligned buffer pointer
// - Second word: EOF, tag, abort, length
// - First-fragment tag kept and posted in status
// - Abort with EOF forces bad CRC always
// - Abort ignored without end-of-frame flag
// - Command field four bits, only abort meaningful
// - Zero-length descriptor skipped, nothing sent
// - Any nonzero byte count accepted, no alignment
// - Status queue circular, aligned, pointer set first
// - Exactly one status entry per frame
package mac_txq_pkg;
  localparam int ADDR_W = 8;
  localparam int LEN_W = 17;
  localparam int CNT_W = 12;
  localparam int TAG_W = 15;
  localparam int TOT_W = 16;
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_DQ_BASE = 8'h04;
  localparam logic [ADDR_W-1:0] A_DQ_LEN = 8'h08;
  localparam logic [ADDR_W-1:0] A_DQ_CUR = 8'h0c;
  localparam logic [ADDR_W-1:0] A_DQ_ENQ = 8'h10;
  localparam logic [ADDR_W-1:0] A_SQ_BASE = 8'h14;
  localparam logic [ADDR_W-1:0] A_SQ_LEN = 8'h18;
  localparam logic [ADDR_W-1:0] A_SQ_CUR = 8'h1c;
  localparam logic [ADDR_W-1:0] A_STATE = 8'h20;
  localparam logic [ADDR_W-1:0] A_FRAMES = 8'h24;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_NOCRC_BIT = 1;
  localparam int ENQ_MSB = 7;
  localparam int EOF_BIT = 31;
  localparam int TAG_MSB = 30;
  localparam int TAG_LSB = 16;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 12;
  localparam int AF_BIT = 15;
  localparam int LEN_MSB = 11;
  localparam int LEN_LSB = 0;
  localparam int STS_DONE_BIT = 31;
  localparam int STS_LEN_MSB = 15;
  localparam logic [31:0] DESC_STEP = 32'h0000_0008;
  localparam logic [31:0] HALF_STEP = 32'h0000_0004;
  localparam logic [31:0] STAT_STEP = 32'h0000_0004;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [1:0] LAST_LANE = 2'h3;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_DESC0 = 6'h02,
    S_DESC1 = 6'h04,
    S_BUFRD = 6'h08,
    S_SEND = 6'h10,
    S_STAT = 6'h20
  } state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic gnt;
    logic rvalid;
    logic [31:0] rdata;
  } mem_rsp_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic first;
    logic last;
    logic add_crc;
    logic bad_crc;
  } tx_s;
endpackage

/* verilog/queue_pointer.sv */
/*
  Circular queue pointer: loadable, advances by a fixed step and wraps to
  the base at the end of the region. Assumes base and length are stable.
*/
`timescale 1ns/1ps
module queue_pointer
  import mac_txq_pkg::*;
#(
  parameter logic [31:0] STEP = DESC_STEP
) (
  input wire logic ref_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic [31:0] base, // region start
  input wire logic [LEN_W-1:0] len, // region bytes
  input wire logic load, // software load
  input wire logic [31:0] load_val, // value to load
  input wire logic advance, // step one entry
  output logic [31:0] cur // current entry address
);
  typedef struct packed {
    logic [31:0] cur;
  } qp_s;

  qp_s r_reg;
  qp_s r_next;
  logic [31:0] stepped;
  logic [32:0] limit;

  always_comb begin
    r_next = r_reg;
    stepped = r_reg.cur + STEP;
    limit = {1'b0, base} + {16'h0000, len};
    if (load) begin
      r_next.cur = load_val;
    end else if (advance) begin
      // Wrap also on 32-bit overflow of the step
      if ({1'b0, stepped} >= limit || stepped < r_reg.cur) begin
        r_next.cur = base;
      end else begin
        r_next.cur = stepped;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cur = r_reg.cur;
endmodule

/* verilog/mac_tx_descriptor_queue.sv */
/*
  Transmit descriptor fetch, fragment gather and status post engine.
  Assumes a memory port that takes a request on gnt and returns read data
  with rvalid at least one cycle later, and a byte-wide line engine that
  handles medium access, preamble and CRC generation.
*/
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module mac_tx_descriptor_queue
  import mac_txq_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic [ADDR_W-1:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  output mem_req_s mem_req, // memory request
  input wire mem_rsp_s mem_rsp, // memory response
  output tx_s tx, // byte stream to line engine
  input wire logic tx_ready // line engine takes byte
);
  typedef struct packed {
    state_e state;
    logic ctrl_en;
    logic no_crc;
    logic [31:0] dq_base;
    logic [LEN_W-1:0] dq_len;
    logic [31:0] sq_base;
    logic [LEN_W-1:0] sq_len;
    logic [TOT_W-1:0] enq_total;
    mem_req_s mem;
    logic issued;
    logic [31:0] buf_ptr;
    logic [31:0] word;
    logic [1:0] lane;
    logic [CNT_W-1:0] left;
    logic eof;
    logic af;
    logic in_frame;
    logic first_pend;
    logic crc_off;
    logic [TAG_W-1:0] tag;
    logic [15:0] frame_len;
    logic [15:0] frames;
    logic [31:0] rdata;
  } main_s;

  main_s r_reg;
  main_s r_next;
  logic [31:0] dq_cur;
  logic [31:0] sq_cur;
  logic dq_load;
  logic sq_load;
  logic dq_adv;
  logic sq_adv;
  logic accepted;
  logic got_data;
  logic [CNT_W-1:0] dlen;
  logic [TOT_W-1:0] total;

  function automatic mem_req_s mk_req(input logic we,
                                      input logic [31:0] addr,
                                      input logic [31:0] wdata);
    mem_req_s m;
    m.req = 1'b1;
    m.we = we;
    m.addr = addr;
    m.wdata = wdata;
    return m;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] b);
    return a == b;
  endfunction

  function automatic logic desc_eof(input logic [31:0] w);
    return w[EOF_BIT];
  endfunction

  // Abort only counts on an end-of-frame descriptor
  function automatic logic desc_abort(input logic [31:0] w);
    return w[AF_BIT] && w[EOF_BIT];
  endfunction

  function automatic logic [TAG_W-1:0] desc_tag(input logic [31:0] w);
    return w[TAG_MSB:TAG_LSB];
  endfunction

  function automatic logic [CNT_W-1:0] desc_len(input logic [31:0] w);
    return w[LEN_MSB:LEN_LSB];
  endfunction

  function automatic logic last_of_buf(input logic [CNT_W-1:0] n);
    return n == CNT_W'(1);
  endfunction

  // Lane 0 always holds the byte on the wire
  function automatic logic [31:0] next_word(input logic [31:0] w);
    return {8'h00, w[31:8]};
  endfunction

  // Enqueue adds only the low byte; larger counts need several writes
  function automatic logic [TOT_W-1:0] enq_add(input logic [TOT_W-1:0] t,
                                               input logic [31:0] w);
    return t + {8'h00, w[ENQ_MSB:0]};
  endfunction

  // Status layout: done flag, first-fragment tag, frame byte count
  function automatic logic [31:0] mk_status(input logic [TAG_W-1:0] t,
                                            input logic [15:0] n);
    logic [31:0] s;
    s = '0;
    s[STS_DONE_BIT] = 1'b1;
    s[TAG_MSB:TAG_LSB] = t;
    s[STS_LEN_MSB:LEN_LSB] = n;
    return s;
  endfunction

  queue_pointer #(
    .STEP(DESC_STEP)
  ) u_dq_ptr (
    .ref_clk(ref_clk),
    .rst(rst),
    .base(r_reg.dq_base),
    .len(r_reg.dq_len),
    .load(dq_load),
    .load_val(reg_wdata),
    .advance(dq_adv),
    .cur(dq_cur)
  );

  queue_pointer #(
    .STEP(STAT_STEP)
  ) u_sq_ptr (
    .ref_clk(ref_clk),
    .rst(rst),
    .base(r_reg.sq_base),
    .len(r_reg.sq_len),
    .load(sq_load),
    .load_val(reg_wdata),
    .advance(sq_adv),
    .cur(sq_cur)
  );

  // Software load wins over a same-cycle hardware advance
  assign dq_load = reg_wr && hit(reg_addr, A_DQ_CUR);
  assign sq_load = reg_wr && hit(reg_addr, A_SQ_CUR);
  assign accepted = r_reg.mem.req && mem_rsp.gnt;
  assign got_data = r_reg.issued && mem_rsp.rvalid;
  assign dlen = desc_len(mem_rsp.rdata);

  always_comb begin
    r_next = r_reg;
    dq_adv = 1'b0;
    sq_adv = 1'b0;
    total = r_reg.enq_total;
    // One access in flight: read data never overlaps a new request
    if (accepted) begin
      r_next.mem.req = 1'b0;
      r_next.issued = !r_reg.mem.we;
    end
    if (got_data) begin
      r_next.issued = 1'b0;
    end
    case (r_reg.state)
      S_IDLE: begin
        // Waits here while nothing is enqueued
        if (r_reg.ctrl_en && r_reg.enq_total != '0) begin
          r_next.mem = mk_req(1'b0, dq_cur, '0);
          r_next.state = S_DESC0;
        end
      end
      S_DESC0: begin
        if (got_data) begin
          r_next.buf_ptr = mem_rsp.rdata;
          r_next.mem = mk_req(1'b0, dq_cur + HALF_STEP, '0);
          r_next.state = S_DESC1;
        end
      end
      S_DESC1: begin
        if (got_data) begin
          dq_adv = 1'b1;
          total = r_reg.enq_total - 1'b1;
          r_next.eof = desc_eof(mem_rsp.rdata);
          // Command bits other than abort are not decoded
          r_next.af = desc_abort(mem_rsp.rdata);
          r_next.left = dlen;
          r_next.lane = '0;
          if (dlen == '0) begin
            r_next.state = S_IDLE;
          end else begin
            if (!r_reg.in_frame) begin
              r_next.in_frame = 1'b1;
              r_next.first_pend = 1'b1;
              r_next.tag = desc_tag(mem_rsp.rdata);
              // CRC choice frozen per frame; later writes cannot split it
              r_next.crc_off = r_reg.no_crc;
              r_next.frame_len = '0;
            end
            r_next.mem = mk_req(1'b0, r_reg.buf_ptr, '0);
            r_next.state = S_BUFRD;
          end
        end
      end
      S_BUFRD: begin
        // One buffer word at a time: no prefetch, simpler, slower
        if (got_data) begin
          r_next.word = mem_rsp.rdata;
          r_next.state = S_SEND;
        end
      end
      S_SEND: begin
        if (tx_ready) begin
          r_next.word = next_word(r_reg.word);
          r_next.lane = r_reg.lane + 2'h1;
          r_next.left = r_reg.left - 1'b1;
          r_next.first_pend = 1'b0;
          r_next.frame_len = r_reg.frame_len + 16'h0001;
          if (last_of_buf(r_reg.left)) begin
            if (r_reg.eof) begin
              r_next.mem = mk_req(1'b1, sq_cur,
                mk_status(r_reg.tag, r_reg.frame_len + 16'h0001));
              r_next.state = S_STAT;
            end else begin
              r_next.state = S_IDLE;
            end
          end else if (r_reg.lane == LAST_LANE) begin
            r_next.buf_ptr = r_reg.buf_ptr + WORD_STEP;
            r_next.mem = mk_req(1'b0, r_reg.buf_ptr + WORD_STEP, '0);
            r_next.state = S_BUFRD;
          end
        end
      end
      S_STAT: begin
        // Status pointer moves only once the write is taken
        if (accepted) begin
          sq_adv = 1'b1;
          r_next.frames = r_reg.frames + 16'h0001;
          r_next.in_frame = 1'b0;
          r_next.state = S_IDLE;
        end
      end
      default: begin
        r_next.state = S_IDLE;
      end
    endcase
    // Host additions and a fetch in the same cycle both count
    if (reg_wr && hit(reg_addr, A_DQ_ENQ)) begin
      total = enq_add(total, reg_wdata);
    end
    r_next.enq_total = total;
    // Writes to read-only or unmapped offsets fall through
    if (reg_wr) begin
      if (hit(reg_addr, A_CTRL)) begin
        r_next.ctrl_en = reg_wdata[CTRL_EN_BIT];
        r_next.no_crc = reg_wdata[CTRL_NOCRC_BIT];
      end
      if (hit(reg_addr, A_DQ_BASE)) begin
        r_next.dq_base = reg_wdata;
      end
      if (hit(reg_addr, A_DQ_LEN)) begin
        r_next.dq_len = reg_wdata[LEN_W-1:0];
      end
      if (hit(reg_addr, A_SQ_BASE)) begin
        r_next.sq_base = reg_wdata;
      end
      if (hit(reg_addr, A_SQ_LEN)) begin
        r_next.sq_len = reg_wdata[LEN_W-1:0];
      end
    end
    r_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        A_CTRL: r_next.rdata = {30'h0, r_reg.no_crc, r_reg.ctrl_en};
        A_DQ_BASE: r_next.rdata = r_reg.dq_base;
        A_DQ_LEN: r_next.rdata = {15'h0, r_reg.dq_len};
        A_DQ_CUR: r_next.rdata = dq_cur;
        A_DQ_ENQ: r_next.rdata = {16'h0, r_reg.enq_total};
        A_SQ_BASE: r_next.rdata = r_reg.sq_base;
        A_SQ_LEN: r_next.rdata = {15'h0, r_reg.sq_len};
        A_SQ_CUR: r_next.rdata = sq_cur;
        A_STATE: r_next.rdata = {25'h0, r_reg.in_frame, r_reg.state};
        A_FRAMES: r_next.rdata = {16'h0, r_reg.frames};
        default: r_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.state <= S_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata = r_reg.rdata;
  assign mem_req = r_reg.mem;

  always_comb begin
    tx.valid = r_reg.state == S_SEND;
    tx.data = r_reg.word[7:0];
    tx.first = r_reg.first_pend;
    tx.last = tx.valid && r_reg.eof && last_of_buf(r_reg.left);
    // Abort corrupts the CRC even when generation is suppressed
    tx.add_crc = tx.last && !r_reg.crc_off && !r_reg.af;
    tx.bad_crc = tx.last && r_reg.af;
  end
endmodule

/* sim/mac_mem_model.sv */
/* Host memory model: one access at a time, optional slow grant.
   Assumes word addresses within the low 1 KB. */
`timescale 1ns/1ps
module mac_mem_model
  import mac_txq_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic slow, // delay each grant
  input wire mem_req_s mem_req, // engine request
  output mem_rsp_s mem_rsp // grant and read data
);
  logic [31:0] m [0:255];
  logic [1:0] wait_reg;
  int n_wr;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_rsp <= '0;
      wait_reg <= 2'h0;
      n_wr <= 0;
    end else begin
      mem_rsp.gnt <= 1'b0;
      mem_rsp.rvalid <= 1'b0;
      // Stale data toggles so nothing leans on it
      mem_rsp.rdata <= ~mem_rsp.rdata;
      if (mem_req.req && !mem_rsp.gnt) begin
        wait_reg <= wait_reg + 2'h1;
        mem_rsp.gnt <= !slow || wait_reg == 2'h3;
      end
      if (mem_req.req && mem_rsp.gnt) begin
        wait_reg <= 2'h0;
        if (mem_req.we) begin
          m[mem_req.addr[9:2]] <= mem_req.wdata;
          n_wr <= n_wr + 1;
        end else begin
          mem_rsp.rvalid <= 1'b1;
          mem_rsp.rdata <= m[mem_req.addr[9:2]];
        end
      end
    end
  end
endmodule

/* sim/mac_tx_descriptor_queue_asserts.sv */
/* Port checker for the transmit queue engine.
   Assumes it is bound to the engine's top module. */
`timescale 1ns/1ps
module mac_tx_descriptor_queue_asserts
  import mac_txq_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst, // async reset
  input wire logic [ADDR_W-1:0] reg_addr, // reg address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [31:0] reg_rdata, // read data
  input wire mem_req_s mem_req, // memory request
  input wire mem_rsp_s mem_rsp, // memory response
  input wire tx_s tx, // byte stream
  input wire logic tx_ready // sink ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  chk_req_held:
    assert property (mem_req.req && !mem_rsp.gnt |=>
      mem_req.req && $stable(mem_req.addr) && $stable(mem_req.we))
    else $error("request changed before grant");
  chk_req_drop:
    assert property (mem_req.req && mem_rsp.gnt |=> !mem_req.req)
    else $error("request held after grant");
  chk_tx_held:
    assert property (tx.valid && !tx_ready |=>
      tx.valid && $stable(tx.data))
    else $error("byte lost while stalled");
  chk_flags_stable:
    assert property (tx.valid && !tx_ready |=> $stable(tx.last)
      && $stable(tx.bad_crc) && $stable(tx.add_crc))
    else $error("end flags changed while stalled");
  chk_status_post:
    assert property (tx.valid && tx.last && tx_ready |->
      ##[1:8] mem_req.req && mem_req.we)
    else $error("no status write after frame end");
  chk_word_addr:
    assert property (mem_req.req |-> mem_req.addr[1:0] == 2'h0)
    else $error("memory access not word aligned");
  chk_status_done:
    assert property (mem_req.req && mem_req.we |->
      mem_req.wdata[STS_DONE_BIT])
    else $error("status entry without done bit");
endmodule
bind mac_tx_descriptor_queue mac_tx_descriptor_queue_asserts u_chk (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rsp(mem_rsp),
  .tx(tx), .tx_ready(tx_ready));

/* sim/test_mac_tx_descriptor_queue.sv */
/* Bench for the transmit queue engine.
   Assumes the memory model; byte at address a is a[7:0]. */
`timescale 1ns/1ps
module test_mac_tx_descriptor_queue
  import mac_txq_pkg::*;
;
  logic ref_clk, rst, reg_wr, reg_rd, tx_ready, slow;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  mem_req_s mem_req;
  mem_rsp_s mem_rsp;
  tx_s tx;
  logic [11:0] got[$];
  int num_errors = 0, cmp_count = 0, cyc = 0;
  mac_tx_descriptor_queue u_dut (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .tx(tx), .tx_ready(tx_ready));
  mac_mem_model u_mem (.ref_clk(ref_clk), .rst(rst), .slow(slow),
    .mem_req(mem_req), .mem_rsp(mem_rsp));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Sink stalls one cycle in three
  always @(posedge ref_clk) begin
    cyc++;
    tx_ready <= (cyc % 3) != 0;
    if (tx.valid === 1'b1 && tx_ready)
      got.push_back({tx.first, tx.last, tx.add_crc & tx.last,
        tx.bad_crc & tx.last, tx.data});
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(input logic [ADDR_W-1:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge ref_clk);
  endtask
  task d(input int s, input logic [31:0] p, w);
    u_mem.m[64 + 2 * s] = p;
    u_mem.m[65 + 2 * s] = w;
  endtask
  task wait_sts(input int n);
    repeat (1000) if (u_mem.n_wr < n) @(posedge ref_clk);
    chk(u_mem.n_wr, n);
  endtask
  task frame(input logic [7:0] b[$], input logic add, bad);
    logic [11:0] g;
    logic [11:0] e;
    logic l;
    foreach (b[i]) begin
      g = got.size() > 0 ? got.pop_front() : 12'hfff;
      l = i == b.size() - 1;
      e = {i == 0, l, add && l, bad && l, b[i]};
      chk(g, e);
    end
  endtask
  task split_frame;
    for (int i = 0; i < 64; i++)
      u_mem.m[i] = {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)};
    d(0, 32'h0, 32'h0005_7003);
    d(1, 32'hc0, 32'h0009_0000);
    d(2, 32'h40, 32'h0001_8002);
    d(3, 32'h80, 32'h8007_0005);
    wr(A_DQ_BASE, 32'h100);
    wr(A_DQ_LEN, 32'h20);
    wr(A_DQ_CUR, 32'h100);
    wr(A_SQ_BASE, 32'h200);
    wr(A_SQ_LEN, 32'h8);
    wr(A_SQ_CUR, 32'h200);
    wr(A_DQ_ENQ, 32'h1);
    wr(A_DQ_ENQ, 32'h1);
    rd(A_DQ_ENQ);
    chk(v, 32'h2);
    wr(A_CTRL, 32'h1);
    repeat (80) @(posedge ref_clk);
    rd(A_DQ_ENQ);
    chk(v, 32'h0);
    chk(got.size(), 3);
    wr(A_DQ_ENQ, 32'h2);
    wait_sts(1);
    frame('{8'h00, 8'h01, 8'h02, 8'h40, 8'h41,
      8'h80, 8'h81, 8'h82, 8'h83, 8'h84}, 1'b1, 1'b0);
    chk(u_mem.m[128], 32'h8005_000a);
    rd(A_DQ_CUR);
    chk(v, 32'h100);
  endtask
  task abort_frame;
    slow <= 1'b1;
    d(0, 32'hc0, 32'h8003_8001);
    d(1, 32'h0, 32'h8004_0004);
    wr(A_CTRL, 32'h3);
    wr(A_DQ_ENQ, 32'h2);
    wait_sts(3);
    frame('{8'hc0}, 1'b0, 1'b1);
    frame('{8'h00, 8'h01, 8'h02, 8'h03}, 1'b0, 1'b0);
    chk(u_mem.m[129], 32'h8003_0001);
    chk(u_mem.m[128], 32'h8004_0004);
    wr(A_FRAMES, 32'hff);
    rd(A_FRAMES);
    chk(v, 32'h3);
    rd(8'h40);
    chk(v, 32'h0);
    rd(A_STATE);
    chk(v[5:0], 6'h01);
    rd(A_DQ_CUR);
    chk(v, 32'h110);
    rd(A_SQ_CUR);
    chk(v, 32'h204);
    rd(A_CTRL);
    chk(v, 32'h3);
    rd(A_SQ_BASE);
    chk(v, 32'h200);
    rd(A_DQ_LEN);
    chk(v, 32'h20);
  endtask
  task print_verdict;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    slow = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    split_frame();
    abort_frame();
    print_verdict();
  end
endmodule
